// File: hw/capability_discovery.sv
// Purpose: card-side capability discovery message engine with APB registers
// Assumes: messages arrive and leave as byte streams on the same clock
// Notes:   short-form length fields only
// Notes on behaviour
// R01: card reports streams, programs and elementary streams as three messages
// R02: host confirms each capacity message with its matching confirmation
// R03: eight message tags run from 0x9FA010 to 0x9FA017, pairs adjacent
// R04: after session opens send stream capacity, count above three
// R05: host stream confirmation 0x9FA011 carries streams it will send
// R06: program capacity message 0x9FA012 carries a count of at least four
// R07: host confirms with 0x9FA013 and 0x9FA015, tag and length only
// R08: elementary stream capacity 0x9FA014 carries a count of at least 16
// R09: elementary count covers host-consumed pids only, never internal ones
// R10: card tells host its required pids; host must keep them
// R11: host accepts a pid list at any time and refilters
// R12: at most eight non-program pids per local stream identifier
// R13: host keeps card-host port traffic below its maximum rate
// R14: host may drop unused pids but keeps required ones
// R15: host pid request has stream id and filtering status 0x00 or 0x01
// R16: pid reply has stream id, count up to eight, 3 zero bits plus pid
// R17: each pid reply is the complete list, replacing earlier ones
// R18: host stores the three maxima and never asks beyond them
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "capability_discovery_cfg.svh"
module capability_discovery #(
  parameter int PID_DEPTH = 8
) (
  input  wire logic        pclk,     // 40 MHz clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction
  input  wire logic [11:0] paddr,    // apb byte address
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr,  // apb error, unmapped address
  input  wire logic        rx_valid, // host message byte valid
  input  wire logic [7:0]  rx_data,  // host message byte
  output logic             rx_ready, // always accepting
  output logic             tx_valid, // card message byte valid
  output logic      [7:0]  tx_data,  // card message byte
  input  wire logic        tx_ready  // host takes byte
);
  import capability_discovery_pkg::*;

  pid_mem_if #(.AW(3), .DW(13)) mem_bus ();
  pid_table #(.DEPTH(PID_DEPTH), .WIDTH(13)) u_table (
    .pclk (pclk),
    .port (mem_bus.mem)
  );

  logic        session_q;
  logic [7:0]  stream_lim_q, decrypt_lim_q, elem_lim_q;
  logic [7:0]  pid_ltsid_q;
  logic [3:0]  pid_cnt_q;
  logic [7:0]  in_use_q, host_ltsid_q, host_filt_q;
  logic [1:0]  evt_q;
  logic        pid_pend_q;
  phase_t      phase_q;
  msg_t        msg_q;
  logic [4:0]  idx_q;
  logic [7:0]  snap_ltsid_q;
  logic [3:0]  snap_cnt_q;
  logic [2:0]  addr_lat_q;
  logic        tx_valid_q;
  logic [7:0]  tx_data_q;

  // apb decode
  logic wr_acc, rd_setup, mapped;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  always_comb begin
    if (paddr == `OFS_CTRL) mapped = 1'b1;
    else if (paddr == `OFS_LIMITS) mapped = 1'b1;
    else if (paddr == `OFS_PID_CFG) mapped = 1'b1;
    else if (paddr == `OFS_PID_ENTRY) mapped = 1'b1;
    else if (paddr == `OFS_STATUS) mapped = 1'b1;
    else if (paddr == `OFS_HOST_EVT) mapped = 1'b1;
    else mapped = 1'b0;
  end
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign rx_ready = 1'b1;
  assign tx_valid = tx_valid_q;
  assign tx_data  = tx_data_q;

  logic wr_ctrl, wr_lim, wr_pcfg, wr_pent, wr_evt;
  assign wr_ctrl = wr_acc & (paddr == `OFS_CTRL);
  assign wr_lim  = wr_acc & (paddr == `OFS_LIMITS);
  assign wr_pcfg = wr_acc & (paddr == `OFS_PID_CFG);
  assign wr_pent = wr_acc & (paddr == `OFS_PID_ENTRY);
  assign wr_evt  = wr_acc & (paddr == `OFS_HOST_EVT);

  assign mem_bus.wr_en   = wr_pent;
  assign mem_bus.wr_addr = pwdata[18:16];
  assign mem_bus.wr_data = pwdata[12:0];

  // limits are clamped on write so the card never advertises below the floor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      session_q     <= 1'b0;
      stream_lim_q  <= `RST_STREAM_LIMIT;
      decrypt_lim_q <= `RST_DECRYPT_LIMIT;
      elem_lim_q    <= `RST_ELEM_LIMIT;
      pid_ltsid_q   <= 8'h00;
      pid_cnt_q     <= 4'h0;
    end else begin
      if (wr_ctrl) session_q <= pwdata[0];
      if (wr_lim) begin
        stream_lim_q  <= (pwdata[7:0] < `MIN_STREAM_LIMIT) ?
                         `MIN_STREAM_LIMIT : pwdata[7:0];            // [R04]
        decrypt_lim_q <= (pwdata[15:8] < `MIN_DECRYPT_LIMIT) ?
                         `MIN_DECRYPT_LIMIT : pwdata[15:8];          // [R06]
        elem_lim_q    <= (pwdata[23:16] < `MIN_ELEM_LIMIT) ?
                         `MIN_ELEM_LIMIT : pwdata[23:16];            // [R08]
      end
      if (wr_pcfg) begin
        pid_ltsid_q <= pwdata[7:0];
        pid_cnt_q   <= (pwdata[11:8] > `MAX_PID_ENTRIES) ?
                       `MAX_PID_ENTRIES : pwdata[11:8];              // [R12]
      end
    end
  end

  // inbound parser: 3 tag bytes, 1 length byte, payload
  logic [23:0] rx_tag_q;
  logic [7:0]  rx_len_q, rx_p0_q, rx_p1_q, rx_cnt_q;
  logic [23:0] done_tag;
  assign done_tag = rx_tag_q;
  logic last_len; // length byte of zero finishes at once
  assign last_len = rx_valid && (rx_cnt_q == 8'h03) && (rx_data == 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_tag_q <= 24'h000000;
      rx_len_q <= 8'h00;
      rx_p0_q  <= 8'h00;
      rx_p1_q  <= 8'h00;
      rx_cnt_q <= 8'h00;
    end else if (rx_valid) begin
      if (rx_cnt_q < 8'h03) rx_tag_q <= {rx_tag_q[15:0], rx_data};
      if (rx_cnt_q == 8'h03) rx_len_q <= rx_data;
      if (rx_cnt_q == 8'h04) rx_p0_q <= rx_data;
      if (rx_cnt_q == 8'h05) rx_p1_q <= rx_data;
      if (last_len || (rx_cnt_q > 8'h03 && rx_cnt_q == rx_len_q + 8'h03)) begin
        rx_cnt_q <= 8'h00;
      end else begin
        rx_cnt_q <= rx_cnt_q + 8'h01;
      end
    end
  end

  // a message is complete on its last byte; payload of the last byte is live
  logic        msg_end;
  logic [7:0]  pay0, pay1;
  assign msg_end = last_len || (rx_valid && rx_cnt_q > 8'h03 &&
                   rx_cnt_q == rx_len_q + 8'h03);
  assign pay0 = (rx_cnt_q == 8'h04) ? rx_data : rx_p0_q;
  assign pay1 = (rx_cnt_q == 8'h05) ? rx_data : rx_p1_q;

  logic ack_stream, ack_decrypt, ack_elem, pid_req, bad_msg;
  assign ack_stream  = msg_end && done_tag == `TAG_STREAM_ACK && phase_q == ph_wait_stream;
  assign ack_decrypt = msg_end && done_tag == `TAG_DECRYPT_ACK &&
                       phase_q == ph_wait_decrypt;                   // [R07]
  assign ack_elem    = msg_end && done_tag == `TAG_ELEM_ACK && phase_q == ph_wait_elem;
  assign pid_req     = msg_end && done_tag == `TAG_PID_REQ;
  assign bad_msg     = msg_end && !ack_stream && !ack_decrypt && !ack_elem && !pid_req;

  // host request latches and event flags; a new event beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_use_q     <= 8'h00;
      host_ltsid_q <= 8'h00;
      host_filt_q  <= 8'h00;
      evt_q        <= 2'b00;
    end else begin
      if (ack_stream) in_use_q <= pay0;                              // [R05]
      if (pid_req) begin
        host_ltsid_q <= pay0;
        host_filt_q  <= pay1;
      end
      evt_q <= (evt_q & ~(wr_evt ? pwdata[1:0] : 2'b00)) | {bad_msg, pid_req};
    end
  end

  // capacity sequence, one confirmation gates the next message
  logic start;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= ph_idle;
    end else if (!session_q) begin
      phase_q <= ph_idle;
    end else begin
      case (phase_q)
        ph_idle:         phase_q <= ph_send_stream;                  // [R04]
        ph_send_stream:  if (start) phase_q <= ph_wait_stream;
        ph_wait_stream:  if (ack_stream) phase_q <= ph_send_decrypt;  // [R01]
        ph_send_decrypt: if (start) phase_q <= ph_wait_decrypt;
        ph_wait_decrypt: if (ack_decrypt) phase_q <= ph_send_elem;
        ph_send_elem:    if (start) phase_q <= ph_wait_elem;
        ph_wait_elem:    if (ack_elem) phase_q <= ph_done;
        default:         phase_q <= phase_q;
      endcase
    end
  end

  // pid replies go on software request or a filtering host request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pid_pend_q <= 1'b0;
    end else if ((wr_pcfg && pwdata[16]) ||
                 (pid_req && pay1 == `FILTER_ON)) begin              // [R10]
      pid_pend_q <= 1'b1;
    end else if (start && msg_q == msg_none && phase_q != ph_send_stream &&
                 phase_q != ph_send_decrypt && phase_q != ph_send_elem) begin
      pid_pend_q <= 1'b0;
    end
  end

  // outbound serializer
  msg_t       next_msg;
  logic [7:0] len_byte, cur_byte;
  logic [4:0] last_idx, off;
  logic [2:0] cur_addr;
  logic       data_ok, load;
  always_comb begin
    if (phase_q == ph_send_stream) next_msg = msg_stream;
    else if (phase_q == ph_send_decrypt) next_msg = msg_decrypt;
    else if (phase_q == ph_send_elem) next_msg = msg_elem;
    else if (pid_pend_q && session_q) next_msg = msg_pids;
    else next_msg = msg_none;
  end
  assign start    = (msg_q == msg_none) && (next_msg != msg_none);
  assign len_byte = (msg_q == msg_pids) ? 8'(8'h02 + {3'b000, snap_cnt_q, 1'b0})
                                        : `PROFILE_LEN;
  assign last_idx = 5'(len_byte[4:0] + 5'h03);
  assign off      = 5'(idx_q - `PID_HDR_BYTES);
  assign cur_addr = off[3:1];
  assign mem_bus.rd_addr = cur_addr;

  always_comb begin
    cur_byte = 8'h00;
    case (idx_q)
      5'h00:   cur_byte = 8'h9F;
      5'h01:   cur_byte = 8'hA0;
      5'h02: begin
        case (msg_q)
          msg_stream:  cur_byte = 8'(`TAG_STREAM_MSG);               // [R03]
          msg_decrypt: cur_byte = 8'(`TAG_DECRYPT_MSG);              // [R06]
          msg_elem:    cur_byte = 8'(`TAG_ELEM_MSG);                 // [R08]
          default:     cur_byte = 8'(`TAG_PID_REPLY);                // [R16]
        endcase
      end
      5'h03:   cur_byte = len_byte;
      5'h04: begin
        case (msg_q)
          msg_stream:  cur_byte = stream_lim_q;                      // [R01]
          msg_decrypt: cur_byte = decrypt_lim_q;
          msg_elem:    cur_byte = elem_lim_q;                        // [R09]
          default:     cur_byte = snap_ltsid_q;
        endcase
      end
      5'h05:   cur_byte = {4'h0, snap_cnt_q};                        // [R16]
      default: cur_byte = off[0] ? mem_bus.rd_data[7:0]
                                 : {3'b000, mem_bus.rd_data[12:8]};  // [R16]
    endcase
  end

  // table read is registered, so wait until the latched address matches
  assign data_ok = (idx_q < `PID_HDR_BYTES) || (addr_lat_q == cur_addr);
  assign load    = (msg_q != msg_none) && (!tx_valid_q || tx_ready) && data_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_q        <= msg_none;
      idx_q        <= 5'h00;
      snap_ltsid_q <= 8'h00;
      snap_cnt_q   <= 4'h0;
      addr_lat_q   <= 3'h0;
      tx_valid_q   <= 1'b0;
      tx_data_q    <= 8'h00;
    end else begin
      addr_lat_q <= cur_addr;
      if (start) begin
        msg_q        <= next_msg;
        idx_q        <= 5'h00;
        snap_ltsid_q <= pid_ltsid_q;
        snap_cnt_q   <= pid_cnt_q;                                   // [R17]
      end else if (load) begin
        tx_valid_q <= 1'b1;
        tx_data_q  <= cur_byte;
        if (idx_q == last_idx) begin
          msg_q <= msg_none;
          idx_q <= 5'h00;
        end else begin
          idx_q <= idx_q + 5'h01;
        end
      end
      if (!load && tx_ready) tx_valid_q <= 1'b0;
    end
  end

  // read data captured in the setup cycle, zero-wait access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      if (paddr == `OFS_CTRL) prdata <= {31'h00000000, session_q};
      else if (paddr == `OFS_LIMITS)
        prdata <= {8'h00, elem_lim_q, decrypt_lim_q, stream_lim_q};
      else if (paddr == `OFS_PID_CFG) prdata <= {20'h00000, pid_cnt_q, pid_ltsid_q};
      else if (paddr == `OFS_STATUS)
        prdata <= {host_filt_q, host_ltsid_q, in_use_q, 2'b00,
                   (msg_q != msg_none), pid_pend_q, 1'b0, phase_q};
      else if (paddr == `OFS_HOST_EVT) prdata <= {30'h00000000, evt_q};
      else prdata <= 32'h00000000;
    end
  end
endmodule : capability_discovery

// File: shared/capability_discovery_cfg.svh
// Purpose: constants for the capability discovery engine
// Assumes: APB register words, short-form length fields
// Notes:   byte offsets, message tags, limits and reset values
`ifndef CAPABILITY_DISCOVERY_CFG_SVH
`define CAPABILITY_DISCOVERY_CFG_SVH

`define OFS_CTRL        12'h000
`define OFS_LIMITS      12'h004
`define OFS_PID_CFG     12'h008
`define OFS_PID_ENTRY   12'h00C
`define OFS_STATUS      12'h010
`define OFS_HOST_EVT    12'h014

`define TAG_STREAM_MSG  24'h9FA010
`define TAG_STREAM_ACK  24'h9FA011
`define TAG_DECRYPT_MSG 24'h9FA012
`define TAG_DECRYPT_ACK 24'h9FA013
`define TAG_ELEM_MSG    24'h9FA014
`define TAG_ELEM_ACK    24'h9FA015
`define TAG_PID_REQ     24'h9FA016
`define TAG_PID_REPLY   24'h9FA017

`define MIN_STREAM_LIMIT  8'h04
`define MIN_DECRYPT_LIMIT 8'h04
`define MIN_ELEM_LIMIT    8'h10
`define MAX_PID_ENTRIES   4'h8

`define RST_STREAM_LIMIT  8'h04
`define RST_DECRYPT_LIMIT 8'h04
`define RST_ELEM_LIMIT    8'h10

`define FILTER_ON       8'h01
`define PROFILE_LEN     8'h01
`define PID_HDR_BYTES   5'h06

`endif

// File: shared/capability_discovery_pkg.sv
// Purpose: types for the capability discovery engine
// Assumes: nothing beyond the cfg header
// Notes:   states and message kinds only
package capability_discovery_pkg;
  typedef enum logic [2:0] {
    ph_idle, ph_send_stream, ph_wait_stream, ph_send_decrypt,
    ph_wait_decrypt, ph_send_elem, ph_wait_elem, ph_done
  } phase_t;

  typedef enum logic [2:0] {
    msg_none, msg_stream, msg_decrypt, msg_elem, msg_pids
  } msg_t;
endpackage : capability_discovery_pkg

// File: shared/pid_mem_if.sv
// Purpose: carries the pid table ports between engine and storage
// Assumes: one write port, one registered read port
// Notes:   widths set by parameters
`timescale 1ns/1ps
interface pid_mem_if #(parameter int AW = 3, parameter int DW = 13);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr,
                input rd_data);
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                output rd_data);
endinterface : pid_mem_if

// File: hw/pid_table.sv
// Purpose: holds the required non-program pid list
// Assumes: read data valid one cycle after the address
// Notes:   contents undefined until software fills them
`timescale 1ns/1ps
module pid_table #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  input  wire logic pclk,   // clock
  pid_mem_if.mem    port    // table access
);
  logic [WIDTH-1:0] store_q [DEPTH];

  always_ff @(posedge pclk) begin
    if (port.wr_en) begin
      store_q[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge pclk) begin
    port.rd_data <= store_q[port.rd_addr];
  end
endmodule : pid_table

// File: testbench/capability_discovery_assertions.sv
// Purpose: port checks for the capability discovery engine
// Assumes: card bytes framed as 3 tag bytes, short length, payload
// Notes:   byte position tracked by a helper counter
`timescale 1ns/1ps
module capability_discovery_checker (
  input wire logic        pclk,     // clock
  input wire logic        presetn,  // reset, active low
  input wire logic        psel,     // apb select
  input wire logic        penable,  // apb access
  input wire logic [11:0] paddr,    // apb address
  input wire logic        pready,   // apb ready
  input wire logic        pslverr,  // apb error
  input wire logic        tx_valid, // card byte valid
  input wire logic [7:0]  tx_data,  // card byte
  input wire logic        tx_ready  // host takes byte
);
  logic [7:0] n_q;
  logic [7:0] len_q;
  logic [7:0] tag_q;
  logic       take;
  assign take = tx_valid && tx_ready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_q <= 8'h00;
    end else if (take) begin
      n_q <= (n_q > 8'h03 && n_q == len_q + 8'h03) ? 8'h00 : n_q + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_q <= 8'h00;
      tag_q <= 8'h00;
    end else if (take && n_q == 8'h03) begin
      len_q <= tx_data;
    end else if (take && n_q == 8'h02) begin
      tag_q <= tx_data;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("apb access without ready");
  property p_unmap; psel && penable && paddr > 12'h014 |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("card byte dropped before taken");
  property p_tag; tx_valid && n_q < 8'h02 |-> tx_data == (n_q == 8'h00 ? 8'h9F : 8'hA0);
  endproperty
  a_tag: assert property (p_tag) else $error("bad tag prefix");
  property p_tag_lo; tx_valid && n_q == 8'h02 |-> tx_data inside {8'h10, 8'h12, 8'h14, 8'h17};
  endproperty
  a_tag_lo: assert property (p_tag_lo) else $error("bad card tag");
  property p_len; tx_valid && n_q == 8'h03 && tag_q != 8'h17 |-> tx_data == 8'h01; endproperty
  a_len: assert property (p_len) else $error("bad profile length");
  property p_smin; tx_valid && n_q == 8'h04 && tag_q == 8'h10 |-> tx_data > 8'h03; endproperty
  a_smin: assert property (p_smin) else $error("stream limit too small");
  property p_dmin; tx_valid && n_q == 8'h04 && tag_q == 8'h12 |-> tx_data >= 8'h04; endproperty
  a_dmin: assert property (p_dmin) else $error("decrypt limit too small");
  property p_emin; tx_valid && n_q == 8'h04 && tag_q == 8'h14 |-> tx_data >= 8'h10; endproperty
  a_emin: assert property (p_emin) else $error("elem limit too small");
  property p_plen;
    tx_valid && n_q == 8'h03 && tag_q == 8'h17 |-> tx_data <= 8'h12 && !tx_data[0];
  endproperty
  a_plen: assert property (p_plen) else $error("bad pid list length");
  property p_pzero;
    tx_valid && n_q > 8'h05 && !n_q[0] && tag_q == 8'h17 |-> tx_data[7:5] == 3'h0;
  endproperty
  a_pzero: assert property (p_pzero) else $error("pid entry top bits set");
  c_stream: cover property (tx_valid && n_q == 8'h02 && tx_data == 8'h10);
  c_elem: cover property (tx_valid && n_q == 8'h02 && tx_data == 8'h14);
  c_pid: cover property (tx_valid && n_q == 8'h02 && tx_data == 8'h17);
endmodule : capability_discovery_checker

bind capability_discovery capability_discovery_checker u_capability_discovery_checker (
  .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .tx_valid, .tx_data, .tx_ready
);

// File: testbench/host_model.sv
// Purpose: host side of the message link
// Assumes: card bytes framed as 3 tag bytes, short length, payload
// Notes:   confirms each profile at once; can stall the card
`timescale 1ns/1ps
module host_model #(
  parameter logic [7:0] IN_USE = 8'h03  // streams the host will send
) (
  input  wire logic       pclk,     // clock
  input  wire logic       presetn,  // reset, active low
  input  wire logic       slow,     // drop ready every other cycle
  input  wire logic       tx_valid, // card byte valid
  input  wire logic [7:0] tx_data,  // card byte
  output logic            tx_ready, // take card byte
  output logic            rx_valid, // host byte valid
  output logic      [7:0] rx_data   // host byte
);
  logic [7:0] got[$];
  logic [7:0] out[$];
  logic [7:0] k = 8'h00;
  logic [7:0] len;
  logic [7:0] tag;
  task automatic push(input logic [7:0] b);
    out.push_back(b);
  endtask : push
  always @(posedge pclk) begin
    if (!presetn) begin
      k = 8'h00;
    end else if (tx_valid && tx_ready) begin
      got.push_back(tx_data); // lists accepted at any time
      if (k == 8'h02) tag = tx_data;
      if (k == 8'h03) len = tx_data;
      if (k > 8'h03 && k == len + 8'h03) begin
        k = 8'h00;
        if (tag == 8'h10 || tag == 8'h12 || tag == 8'h14) begin
          push(8'h9F);
          push(8'hA0);
          push(tag + 8'h01);
          push(tag == 8'h10 ? 8'h01 : 8'h00);
          // never ask for more streams than the card offered
          if (tag == 8'h10) push(IN_USE > tx_data ? tx_data : IN_USE);
        end
      end else begin
        k = k + 8'h01;
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      rx_valid <= out.size() > 0; // one byte a cycle at most, the port's top rate
      // idle line drives the inverse of rx_data each cycle
      rx_data  <= out.size() > 0 ? out.pop_front() : ~rx_data;
    end
  end
endmodule : host_model

// File: testbench/capability_discovery_bench.sv
// Purpose: self-checking bench for the capability discovery engine
// Assumes: zero wait apb slave, host model on the message link
// Notes:   pid table slots beyond those written stay unread
`timescale 1ns/1ps
module capability_discovery_bench;
  logic        pclk, presetn, psel, penable, pwrite, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, rx_ready, rx_valid, tx_valid, tx_ready, err_q;
  logic [7:0]  rx_data, tx_data;
  int          err_total, n_tests;
  capability_discovery u_capability_discovery (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_ready, .tx_valid,
    .tx_data, .tx_ready);
  host_model u_host_model (.pclk, .presetn, .slow, .tx_valid, .tx_data, .tx_ready,
    .rx_valid, .rx_data);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic conclude;
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd_q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      err_total++;
      conclude();
    end
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask : rd
  task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
    int i;
    i = 0;
    do begin
      apb(1'b0, a, 32'h0);
      i++;
    end while ((rd_q & m) !== v && i < 40);
    if (i >= 40) begin
      err_total++;
      conclude();
    end
  endtask : poll
  task automatic send(input logic [7:0] e[$]);
    foreach (e[j]) u_host_model.push(e[j]);
  endtask : send
  task automatic expect_msg(input logic [7:0] e[$]);
    int i;
    i = 0;
    while (u_host_model.got.size() < e.size() && i < 400) begin
      @(posedge pclk);
      i++;
    end
    if (i >= 400) begin
      err_total++;
      conclude();
    end
    foreach (e[j]) chk(u_host_model.got[j], e[j]);
    u_host_model.got.delete();
  endtask : expect_msg
  task automatic t_regs;
    rd(12'h004, 32'h0010_0404);
    rd(12'h010, 32'h0);
    apb(1'b1, 12'h004, 32'h000F_0302);
    rd(12'h004, 32'h0010_0404);
    apb(1'b1, 12'h004, 32'h0011_0504);
    rd(12'h004, 32'h0011_0504);
    rd(12'h020, 32'h0);
    chk(err_q, 1'b1);
    chk(rx_ready, 32'h1);
  endtask : t_regs
  task automatic t_session;
    slow <= 1'b1;
    apb(1'b1, 12'h000, 32'h1);
    expect_msg('{8'h9F, 8'hA0, 8'h10, 8'h01, 8'h04, 8'h9F, 8'hA0, 8'h12, 8'h01, 8'h05,
      8'h9F, 8'hA0, 8'h14, 8'h01, 8'h11});
    poll(12'h010, 32'h7, 32'h7);
    chk(rd_q, 32'h0000_0307);
    rd(12'h014, 32'h0);
    send('{8'h9F, 8'hA0, 8'h13, 8'h00});
    poll(12'h014, 32'h2, 32'h2);
    chk(rd_q, 32'h2);
    apb(1'b1, 12'h014, 32'h2);
    rd(12'h014, 32'h0);
  endtask : t_session
  task automatic t_pids;
    slow <= 1'b0;
    apb(1'b1, 12'h00C, 32'h0000_1FFF);
    apb(1'b1, 12'h00C, 32'h0001_0123);
    apb(1'b1, 12'h008, 32'h0001_0207);
    expect_msg('{8'h9F, 8'hA0, 8'h17, 8'h06, 8'h07, 8'h02, 8'h1F, 8'hFF, 8'h01,
      8'h23});
    apb(1'b1, 12'h008, 32'h0001_0107);
    expect_msg('{8'h9F, 8'hA0, 8'h17, 8'h04, 8'h07, 8'h01, 8'h1F, 8'hFF});
    apb(1'b1, 12'h008, 32'h0000_0905);
    rd(12'h008, 32'h0000_0805);
    apb(1'b1, 12'h008, 32'h0000_0105);
    send('{8'h9F, 8'hA0, 8'h16, 8'h02, 8'h06, 8'h01});
    expect_msg('{8'h9F, 8'hA0, 8'h17, 8'h04, 8'h05, 8'h01, 8'h1F, 8'hFF});
    rd(12'h014, 32'h1);
    rd(12'h010, 32'h0106_0307);
    send('{8'h9F, 8'hA0, 8'h16, 8'h02, 8'h09, 8'h00});
    poll(12'h010, 32'hFFFF_0000, 32'h0009_0000);
    chk(32'(u_host_model.got.size()), 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    rd(12'h010, 32'h0009_0300);
  endtask : t_pids
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slow = 1'b0;
    err_total = 0;
    n_tests = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_session();
    t_pids();
    conclude();
  end
endmodule : capability_discovery_bench
